// file: rtl/fdb_pkg.sv
// package: constants and carriers for the floppy drive bus interface
package fdb_pkg;

  // drive bus geometry
  localparam int unsigned DRIVE_COUNT     = 4;
  localparam int unsigned TRACK_W         = 7;
  localparam logic [6:0]  INNER_TRACK_MIN = 7'h2C;  // first track past 43

  // clock rate
  localparam int unsigned CLK_MHZ = 100;

  // step pulse low time and step-to-step spacing, in microseconds
  localparam int unsigned STEP_LOW_US  = 1;
  localparam int unsigned STEP_RATE_US = 3000;
  localparam int unsigned STEP_LOW_CYC = STEP_LOW_US * CLK_MHZ;
  localparam int unsigned STEP_RATE_CYC_DEF = STEP_RATE_US * CLK_MHZ;

  // direction setup before the step edge, in nanoseconds
  localparam int unsigned DIR_SETUP_NS  = 1000;
  localparam int unsigned DIR_SETUP_CYC = (DIR_SETUP_NS + 9) / 10;

  // write pulse width in cycles (least one cycle)
  localparam int unsigned WPULSE_NS  = 200;
  localparam int unsigned WPULSE_CYC = (WPULSE_NS + 9) / 10;

  // reset values
  localparam logic [6:0] TRACK_RST = 7'h00;

  // head step direction: high toward centre
  localparam logic DIR_IN  = 1'b1;
  localparam logic DIR_OUT = 1'b0;

  // user command for the controller
  typedef struct packed {
    logic [1:0] drive;       // drive index 0..3
    logic       select;      // any drive selected
    logic       motor_on;
    logic       head_load;
    logic       side;        // 0 or 1
    logic       large_fmt;   // 8-inch drive attached
    logic       eject;
  } fdb_ctrl_type;

  // drive status seen by the user, active high
  typedef struct packed {
    logic index;
    logic outer_track;
    logic write_lock;
    logic ready;
    logic two_sided;
    logic seek_done;
  } fdb_stat_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PULSE,
    ST_WAIT
  } fdb_step_state_type;

endpackage

// file: rtl/fdb_stepper.sv
// step pulse generator with direction setup and step-rate spacing
`timescale 1ns/1ps
module fdb_stepper
  import fdb_pkg::*;
#(
  parameter int unsigned STEP_RATE_CYC = STEP_RATE_CYC_DEF
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // request
  input  wire logic req_i,
  input  wire logic dir_i,
  // result
  output logic      busy_o,
  output logic      step_n_o,
  output logic      dir_o,
  output logic      done_o
);

  // counter must hold the longest of the three loads, not just the spacing,
  // or a short simulation spacing would wrap the setup and pulse counts
  localparam int unsigned CMAX0 = (STEP_RATE_CYC > STEP_LOW_CYC)
                                  ? STEP_RATE_CYC : STEP_LOW_CYC;
  localparam int unsigned CMAX  = (CMAX0 > DIR_SETUP_CYC)
                                  ? CMAX0 : DIR_SETUP_CYC;
  localparam int unsigned CW    = $clog2(CMAX + 1);

  fdb_step_state_type state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          step_n_ff, nxt_step_n;
  logic          dir_ff, nxt_dir;
  logic          done_ff, nxt_done;

  // one negative pulse per request, then hold off for the step rate
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_step_n = 1'b1;
    nxt_dir    = dir_ff;
    nxt_done   = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (req_i) begin
          nxt_dir   = dir_i;
          nxt_cnt   = CW'(DIR_SETUP_CYC);
          nxt_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_ff <= CW'(1)) begin
          nxt_cnt    = CW'(STEP_LOW_CYC);
          nxt_step_n = 1'b0;
          nxt_state  = ST_PULSE;
        end else begin
          nxt_cnt = cnt_ff - CW'(1);
        end
      end
      ST_PULSE: begin
        if (cnt_ff <= CW'(1)) begin
          nxt_cnt   = CW'(STEP_RATE_CYC);
          nxt_state = ST_WAIT;
          nxt_done  = 1'b1;
        end else begin
          nxt_step_n = 1'b0;
          nxt_cnt    = cnt_ff - CW'(1);
        end
      end
      ST_WAIT: begin
        // spacing lets the drive settle before the next step
        if (cnt_ff <= CW'(1)) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - CW'(1);
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= '0;
      step_n_ff <= 1'b1;
      dir_ff    <= DIR_OUT;
      done_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      step_n_ff <= nxt_step_n;
      dir_ff    <= nxt_dir;
      done_ff   <= nxt_done;
    end
  end

  assign busy_o   = (state_ff != ST_IDLE);
  assign step_n_o = step_n_ff;
  assign dir_o    = dir_ff;
  assign done_o   = done_ff;

endmodule

// file: rtl/fdb_ctrl.sv
// drive bus side of a floppy disk controller
`timescale 1ns/1ps
module fdb_ctrl
  import fdb_pkg::*;
#(
  parameter int unsigned STEP_RATE_CYC = STEP_RATE_CYC_DEF
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  // user control
  input  wire fdb_ctrl_type ctrl_i,
  input  wire logic         step_req_i,
  input  wire logic         step_dir_i,
  input  wire logic         restore_i,
  input  wire logic         write_req_i,
  input  wire logic         write_bit_i,
  input  wire logic         error_clr_i,
  // user status
  output fdb_stat_type      stat_o,
  output logic              read_pulse_o,
  output logic [6:0]        track_o,
  output logic              step_busy_o,
  output logic              write_active_o,
  output logic              write_error_o,
  // drive bus outputs
  output logic [3:0]        drive_choice_lines_o,
  output logic              motor_on_n_o,
  output logic              step_n_o,
  output logic              step_direction_o,
  output logic              write_gate_n_o,
  output logic              write_data_n_o,
  output logic              side_choice_o,
  output logic              inner_track_n_o,
  output logic              head_contact_n_o,
  output logic              eject_n_o,
  // drive bus inputs, all active low
  input  wire logic         index_n_i,
  input  wire logic         outer_track_flag_n_i,
  input  wire logic         write_lock_flag_n_i,
  input  wire logic         read_data_n_i,
  input  wire logic         ready_n_i,
  input  wire logic         two_sided_n_i,
  input  wire logic         seek_done_n_i
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers for the drive pins

  localparam int unsigned NIN = 7;
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] sync1_ff;
  logic [NIN-1:0] sync2_ff;
  logic [NIN-1:0] nxt_sync1;
  logic [NIN-1:0] nxt_sync2;

  assign pin_raw = {seek_done_n_i, two_sided_n_i, ready_n_i, read_data_n_i,
                    write_lock_flag_n_i, outer_track_flag_n_i, index_n_i};

  // two flops per pin, first stage read only by the second
  always_comb begin
    nxt_sync1 = pin_raw;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= {NIN{1'b1}};
      sync2_ff <= {NIN{1'b1}};
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // synchronised levels, active high
  logic idx_s, trk0_s, wlock_s, rd_s, rdy_s, two_s, seek_s;
  assign idx_s   = ~sync2_ff[0];
  assign trk0_s  = ~sync2_ff[1];
  assign wlock_s = ~sync2_ff[2];
  assign rd_s    = ~sync2_ff[3];
  assign rdy_s   = ~sync2_ff[4];
  assign two_s   = ~sync2_ff[5];
  assign seek_s  = ~sync2_ff[6];

  ////////////////////////////////////////////////////////////////////////
  // head stepping

  logic step_go;
  logic stepper_busy;
  logic stepper_step_n;
  logic stepper_dir;
  logic stepper_done;
  logic step_dir_req;

  // restore steps outward until the outer-track flag shows
  assign step_dir_req = restore_i ? DIR_OUT : step_dir_i;
  assign step_go = !stepper_busy && !write_active_o
                   && (step_req_i || (restore_i && !trk0_s));

  fdb_stepper #(
    .STEP_RATE_CYC (STEP_RATE_CYC)
  ) u_stepper (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .req_i    (step_go),
    .dir_i    (step_dir_req),
    .busy_o   (stepper_busy),
    .step_n_o (stepper_step_n),
    .dir_o    (stepper_dir),
    .done_o   (stepper_done)
  );

  // track counter follows each issued step; outer flag forces zero while the stepper is idle with direction out
  logic [6:0] track_ff, nxt_track;

  always_comb begin
    nxt_track = track_ff;
    if (trk0_s && stepper_dir == DIR_OUT && !stepper_busy) begin
      nxt_track = TRACK_RST;
    end else if (stepper_done) begin
      if (stepper_dir == DIR_IN) begin
        nxt_track = (track_ff == 7'h7F) ? track_ff : track_ff + 7'h01;
      end else if (track_ff != 7'h00) begin
        nxt_track = track_ff - 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write path and protection check

  logic wact_ff, nxt_wact;
  logic werr_ff, nxt_werr;
  logic wdat_ff, nxt_wdat;
  logic [7:0] wcnt_ff, nxt_wcnt;

  // write gate only while asked and media not locked; bits become pulses
  always_comb begin
    nxt_wact = write_req_i && ctrl_i.select && !wlock_s
               && !stepper_busy;
    nxt_werr = werr_ff;
    if (error_clr_i) begin
      nxt_werr = 1'b0;
    end
    if (write_req_i && wlock_s) begin
      nxt_werr = 1'b1;
    end
    nxt_wcnt = (wcnt_ff != 8'h00) ? wcnt_ff - 8'h01 : 8'h00;
    if (wact_ff && write_bit_i) begin
      nxt_wcnt = 8'(WPULSE_CYC);
    end
    nxt_wdat = wact_ff && (nxt_wcnt != 8'h00);
  end

  ////////////////////////////////////////////////////////////////////////
  // bus output and status registers

  logic [3:0]   sel_ff, nxt_sel;
  logic         motor_n_ff, nxt_motor_n;
  logic         step_n_ff, dir_ff;
  logic         side_ff, nxt_side;
  logic         inner_n_ff, nxt_inner_n;
  logic         head_n_ff, nxt_head_n;
  logic         eject_n_ff, nxt_eject_n;
  fdb_stat_type stat_ff, nxt_stat;
  logic         rd_prev_ff, rd_pulse_ff, nxt_rd_pulse;
  logic         busy_ff;

  // drive-facing levels; optional inputs only reported, never awaited
  always_comb begin
    nxt_sel = 4'h0;
    if (ctrl_i.select) begin
      nxt_sel[ctrl_i.drive] = 1'b1;
    end
    nxt_motor_n = ~ctrl_i.motor_on;
    nxt_side    = ~ctrl_i.side;
    nxt_inner_n = ~(ctrl_i.large_fmt
                   && track_ff >= INNER_TRACK_MIN);
    nxt_head_n  = ~(ctrl_i.large_fmt && ctrl_i.head_load);
    nxt_eject_n = ~(ctrl_i.eject && ctrl_i.select);
    nxt_stat.index       = idx_s;
    nxt_stat.outer_track = trk0_s;
    nxt_stat.write_lock  = wlock_s;
    nxt_stat.ready       = rdy_s;
    nxt_stat.two_sided   = two_s;
    nxt_stat.seek_done   = seek_s;
    nxt_rd_pulse = rd_s && !rd_prev_ff;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      track_ff    <= TRACK_RST;
      wact_ff     <= 1'b0;
      werr_ff     <= 1'b0;
      wdat_ff     <= 1'b0;
      wcnt_ff     <= 8'h00;
      sel_ff      <= 4'h0;
      motor_n_ff  <= 1'b1;
      step_n_ff   <= 1'b1;
      dir_ff      <= DIR_OUT;
      side_ff     <= 1'b1;
      inner_n_ff  <= 1'b1;
      head_n_ff   <= 1'b1;
      eject_n_ff  <= 1'b1;
      stat_ff     <= '0;
      rd_prev_ff  <= 1'b0;
      rd_pulse_ff <= 1'b0;
      busy_ff     <= 1'b0;
    end else begin
      track_ff    <= nxt_track;
      wact_ff     <= nxt_wact;
      werr_ff     <= nxt_werr;
      wdat_ff     <= nxt_wdat;
      wcnt_ff     <= nxt_wcnt;
      sel_ff      <= nxt_sel;
      motor_n_ff  <= nxt_motor_n;
      step_n_ff   <= stepper_step_n;
      dir_ff      <= stepper_dir;
      side_ff     <= nxt_side;
      inner_n_ff  <= nxt_inner_n;
      head_n_ff   <= nxt_head_n;
      eject_n_ff  <= nxt_eject_n;
      stat_ff     <= nxt_stat;
      rd_prev_ff  <= rd_s;
      rd_pulse_ff <= nxt_rd_pulse;
      busy_ff     <= stepper_busy || step_go;
    end
  end

  // every output straight from a flop
  assign drive_choice_lines_o = sel_ff;
  assign motor_on_n_o         = motor_n_ff;
  assign step_n_o             = step_n_ff;
  assign step_direction_o     = dir_ff;
  assign write_gate_n_o       = ~wact_ff;
  assign write_data_n_o       = ~wdat_ff;
  assign side_choice_o        = side_ff;
  assign inner_track_n_o      = inner_n_ff;
  assign head_contact_n_o     = head_n_ff;
  assign eject_n_o            = eject_n_ff;
  assign stat_o               = stat_ff;
  assign read_pulse_o         = rd_pulse_ff;
  assign track_o              = track_ff;
  assign step_busy_o          = busy_ff;
  assign write_active_o       = wact_ff;
  assign write_error_o        = werr_ff;

endmodule

// file: testbench/fdb_ctrl_chk.sv
// port checker for the floppy drive bus controller
`timescale 1ns/1ps
module fdb_ctrl_chk
  import fdb_pkg::*;
(
  // clock, reset and user side
  input wire logic         clock_i,
  input wire logic         rst_n_i,
  input wire fdb_ctrl_type ctrl_i,
  input wire logic [6:0]   track_o,
  input wire logic         step_busy_o,
  input wire logic         write_active_o,
  input wire logic         write_req_i,
  input wire logic         write_error_o,
  // drive bus outputs
  input wire logic [3:0]   drive_choice_lines_o,
  input wire logic         motor_on_n_o,
  input wire logic         step_n_o,
  input wire logic         step_direction_o,
  input wire logic         write_gate_n_o,
  input wire logic         side_choice_o,
  input wire logic         inner_track_n_o,
  input wire logic         head_contact_n_o,
  input wire logic         eject_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////
  a_one_drive: assert property ($onehot0(drive_choice_lines_o))
    else $error("two drives selected");
  a_drive_map: assert property (drive_choice_lines_o ==
    ($past(ctrl_i.select) ? 4'h1 << $past(ctrl_i.drive) : 4'h0))
    else $error("select lines do not follow drive index");
  a_motor_cmd: assert property (motor_on_n_o == !$past(ctrl_i.motor_on))
    else $error("motor line wrong");
  a_side_code: assert property (side_choice_o == !$past(ctrl_i.side))
    else $error("side line wrong");
  a_eject_cmd: assert property (eject_n_o ==
    !$past(ctrl_i.eject && ctrl_i.select))
    else $error("eject line wrong");
  a_head_large: assert property (head_contact_n_o ==
    !$past(ctrl_i.head_load && ctrl_i.large_fmt))
    else $error("head contact wrong");
  // both causes steady, so either registering order gives the same level
  a_inner_flag: assert property ($stable(track_o) &&
    $stable(ctrl_i.large_fmt) |-> inner_track_n_o ==
    !(ctrl_i.large_fmt && track_o > 7'h2B))
    else $error("inner track flag wrong");
  a_gate_active: assert property (!write_gate_n_o |->
    write_active_o && $past(write_req_i) && $past(ctrl_i.select))
    else $error("write gate open without a request");
  a_lock_refuse: assert property ($rose(write_error_o) |-> write_gate_n_o)
    else $error("gate opened on locked media");
  a_dir_hold: assert property (!step_n_o |-> $stable(step_direction_o))
    else $error("direction moved during step pulse");
  a_step_width: assert property ($fell(step_n_o) |->
    (!step_n_o && step_busy_o) [*8])
    else $error("step pulse too short");
endmodule

bind fdb_ctrl fdb_ctrl_chk i_fdb_ctrl_chk (.*);

// file: testbench/fdb_drive_model.sv
// behavioural model of the drives hanging on the drive bus
`timescale 1ns/1ps
module fdb_drive_model (
  // from the controller
  input  wire logic       clock_i,
  input  wire logic [3:0] sel_i,
  input  wire logic       step_n_i,
  input  wire logic       dir_i,
  input  wire logic       motor_n_i,
  // bench knobs
  input  wire logic       lock_i,
  input  wire logic       two_i,
  // to the controller, pulled high when deselected; head_o gives the head position to the bench
  output logic            index_n_o,
  output logic            outer_n_o,
  output logic            lock_n_o,
  output logic            rdata_n_o,
  output logic            ready_n_o,
  output logic            two_n_o,
  output logic            seek_n_o,
  output int              head_o
);
  int  cyc = 0;
  int  spin = 0;
  int  t_step = 0;
  wire s = |sel_i;
  initial head_o = 3;  // start off track zero so a restore has work

  ////////////////////////////////////////////////////////////////////////
  // one track per falling step edge; the stop at track 00 is mechanical
  always @(negedge step_n_i) begin
    if (s && dir_i)
      head_o <= head_o + 1;
    else if (s && head_o > 0)
      head_o <= head_o - 1;
    t_step <= cyc;
  end
  // disk rotation and spindle spin-up
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    spin <= motor_n_i ? 0 : spin + 1;
  end
  // status lines, active low
  assign index_n_o = !(s && cyc % 500 < 5);
  assign outer_n_o = !(s && head_o == 0);
  assign lock_n_o  = !(s && lock_i);
  assign rdata_n_o = !(s && cyc % 37 < 4);
  assign ready_n_o = !(s && spin > 30);
  assign two_n_o   = !(s && two_i);
  assign seek_n_o  = !(s && cyc - t_step > 20);
endmodule

// file: testbench/fdb_ctrl_tb_top.sv
// self-checking bench for the floppy drive bus controller
`timescale 1ns/1ps
module fdb_ctrl_tb_top;
  import fdb_pkg::*;
  localparam int unsigned RATE = 50;  // short step spacing keeps runs brief
  logic clock_i = 1'b0, rst_n_i = 1'b0, step_req_i = 1'b0;
  logic step_dir_i = 1'b0, restore_i = 1'b0, write_req_i = 1'b0;
  logic write_bit_i = 1'b0, error_clr_i = 1'b0, lock = 1'b0, two = 1'b0;
  fdb_ctrl_type ctrl_i = '0;
  fdb_stat_type stat_o;
  logic [6:0] track_o;
  logic [3:0] drive_choice_lines_o;
  logic read_pulse_o, step_busy_o, write_active_o, write_error_o;
  logic motor_on_n_o, step_n_o, step_direction_o, write_gate_n_o;
  logic write_data_n_o, side_choice_o, inner_track_n_o, head_contact_n_o;
  logic eject_n_o, index_n_i, outer_track_flag_n_i, write_lock_flag_n_i;
  logic read_data_n_i, ready_n_i, two_sided_n_i, seek_done_n_i;
  int head, n, n_step = 0, n_wr = 0, n_rd = 0, cyc = 0, n_fail = 0;
  int total_checks = 0, seed = 32'h6dda92ce;
  int n_idx = 0;
  logic idx_prev = 1'b0;

  fdb_ctrl #(.STEP_RATE_CYC(RATE)) i_fdb_ctrl (.*);
  fdb_drive_model i_fdb_drive_model (.clock_i, .sel_i(drive_choice_lines_o),
    .step_n_i(step_n_o), .dir_i(step_direction_o), .motor_n_i(motor_on_n_o),
    .lock_i(lock), .two_i(two), .index_n_o(index_n_i),
    .outer_n_o(outer_track_flag_n_i), .lock_n_o(write_lock_flag_n_i),
    .rdata_n_o(read_data_n_i), .ready_n_o(ready_n_i),
    .two_n_o(two_sided_n_i), .seek_n_o(seek_done_n_i), .head_o(head));

  ////////////////////////////////////////////////////////////////////////
  initial forever #5 clock_i = ~clock_i;
  always @(negedge step_n_o) n_step++;
  always @(negedge write_data_n_o) n_wr++;
  // read and index pulse counts, hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (read_pulse_o === 1'b1) n_rd++;
    if (stat_o.index === 1'b1 && idx_prev !== 1'b1) n_idx++;
    idx_prev = stat_o.index;
    if (cyc == 40000) begin
      n_fail++;
      give_verdict();
    end
  end

  function automatic logic [3:0] exp_sel(fdb_ctrl_type c);
    return c.select ? 4'h1 << c.drive : 4'h0;
  endfunction
  function automatic logic exp_head(fdb_ctrl_type c);
    return !(c.head_load && c.large_fmt);
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  // one step request at a rising edge, then wait out the busy time
  task automatic step(input logic d);
    int k;
    k = 0;
    @(posedge clock_i);
    step_dir_i <= d;
    step_req_i <= 1'b1;
    tick(1);
    step_req_i <= 1'b0;
    tick(3);
    while (step_busy_o !== 1'b0 && k < 2000) begin
      tick(1);
      k++;
    end
    tick(2);
    @(negedge clock_i);  // settled outputs for the caller's checks
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    rst_n_i <= 1'b1;
    // random commands, then eject while deselected and drive 3 by hand
    for (n = 0; n < 18; n++) begin
      @(posedge clock_i);
      if (n == 16) begin
        ctrl_i <= 8'h01;
      end else if (n == 17) begin
        ctrl_i <= 8'hE2;
      end else begin
        ctrl_i <= 8'($random(seed));
      end
      tick(2);
      @(negedge clock_i);
      chk("select", drive_choice_lines_o, exp_sel(ctrl_i));
      chk("motor", motor_on_n_o, !ctrl_i.motor_on);
      chk("side", side_choice_o, !ctrl_i.side);
      chk("eject", eject_n_o, !(ctrl_i.eject && ctrl_i.select));
      chk("hload", head_contact_n_o, exp_head(ctrl_i));
    end
    $display("test levels done");
    // restore from track 3: drive 0, motor, head, large format
    @(posedge clock_i);
    ctrl_i <= 8'h3A;
    n_step = 0;
    restore_i <= 1'b1;
    tick(4);
    n = 0;
    while ((stat_o.outer_track !== 1'b1 || step_busy_o !== 1'b0)
           && n < 3000) begin
      tick(1);
      n++;
    end
    restore_i <= 1'b0;
    tick(2);
    @(negedge clock_i);
    chk("track", track_o, 7'h00);
    chk("outer", stat_o.outer_track, 1'b1);
    chk("steps", n_step, 3);
    chk("head", head, 0);
    $display("test restore done");
    // step to the inner-track boundary and back
    n_step = 0;
    repeat (43) step(DIR_IN);
    chk("track", track_o, 7'h2B);
    chk("inner", inner_track_n_o, 1'b1);
    step(DIR_IN);
    chk("head", head, 44);
    chk("dir", step_direction_o, DIR_IN);
    chk("track", track_o, 7'h2C);
    chk("inner", inner_track_n_o, 1'b0);
    step(DIR_OUT);
    chk("dir", step_direction_o, DIR_OUT);
    chk("inner", inner_track_n_o, 1'b1);
    chk("seek", stat_o.seek_done, 1'b1);
    chk("steps", n_step, 45);
    $display("test stepping done");
    // write a random number of flux pulses
    n = ($random(seed) & 3) + 2;
    n_wr = 0;
    @(posedge clock_i);
    write_req_i <= 1'b1;
    tick(2);
    chk("gate", write_gate_n_o, 1'b0);
    repeat (n) begin
      write_bit_i <= 1'b1;
      tick(1);
      write_bit_i <= 1'b0;
      tick(25);
    end
    chk("pulses", n_wr, n);
    write_req_i <= 1'b0;
    tick(3);
    chk("gate", write_gate_n_o, 1'b1);
    $display("test write done");
    // locked media refuses the gate and raises the error
    lock <= 1'b1;
    two <= 1'b1;
    tick(6);
    chk("lock", stat_o.write_lock, 1'b1);
    chk("two", stat_o.two_sided, 1'b1);
    chk("ready", stat_o.ready, 1'b1);
    write_req_i <= 1'b1;
    tick(3);
    chk("gate", write_gate_n_o, 1'b1);
    chk("error", write_error_o, 1'b1);
    write_req_i <= 1'b0;
    error_clr_i <= 1'b1;
    tick(1);
    error_clr_i <= 1'b0;
    tick(2);
    chk("error", write_error_o, 1'b0);
    // a refused request in the clearing cycle keeps the error set
    write_req_i <= 1'b1;
    error_clr_i <= 1'b1;
    tick(1);
    write_req_i <= 1'b0;
    error_clr_i <= 1'b0;
    tick(2);
    chk("error", write_error_o, 1'b1);
    error_clr_i <= 1'b1;
    tick(1);
    error_clr_i <= 1'b0;
    tick(2);
    chk("error", write_error_o, 1'b0);
    $display("test lock done");
    // ten read pulses per 370 cycles, two index pulses per 1000
    @(negedge clock_i);
    n_rd = 0;
    tick(370);
    @(negedge clock_i);
    chk("reads", n_rd, 10);
    n_idx = 0;
    tick(1000);
    @(negedge clock_i);
    chk("index", n_idx, 2);
    $display("test read done");
    give_verdict();
  end
endmodule
